//--- allc_light_comparator.sv
`timescale 1ns/1ps
// Functional notes
// - config bits 7 to 5 select a smoothing period of 0.08 s doubling per code up to 10.24 s.
// - writing the one-shot bit makes the comparators take one sample, skipped by a comparator whose code changed since the last sample.
// - the one-shot bit clears itself once that sample has been taken.
// - dark status reads 1 after light falls below the dark level and 0 once it rises above that level plus hysteresis.
// - office status reads 1 after light falls below the office level and 0 once it rises above that level plus hysteresis.
// - the dark comparator works only while its enable bit is 1.
// - the office comparator works only while config bit 0 is 1.
// - office status sets when light falls below the office threshold, 4 uA per code.
// - office status clears once light rises above office threshold plus hysteresis, or when the office comparator is disabled.
// - dark status sets when light falls below the dark threshold, 0.5 uA per code.
// - dark status clears once light rises above dark threshold plus hysteresis, or when the dark comparator is disabled.
// - the light level picks which max and dim pair of 0x05 to 0x0a the backlight uses.
module allc_light_comparator (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] office_light_code,
    input wire logic [6:0] dark_light_code,
    output logic [1:0] backlight_light_level,
    output logic [7:0] level_max_addr,
    output logic [7:0] level_dim_addr
);
    logic [2:0] smoothing_period;
    logic force_req;
    logic dark_comparator_enable;
    logic office_comparator_enable;
    logic [6:0] office_threshold;
    logic [6:0] office_hysteresis;
    logic [6:0] dark_threshold;
    logic [6:0] dark_hysteresis;
    logic [6:0] off_s1, off_s2, off_s3;
    logic [6:0] drk_s1, drk_s2, drk_s3;
    logic [6:0] off_light, drk_light;
    logic [31:0] tick_cnt;
    logic [7:0] step_cnt;
    logic off_pend, drk_pend;
    logic [1:0] next_level;
    allc_cmp_if office_bus ();
    allc_cmp_if dark_bus ();
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_ARMED = 2'b10
    } allc_seq_e;
    allc_seq_e seq_state;
    allc_seq_e next_seq_state;

    wire wr_cfg = reg_wr && reg_addr == allc_pkg::ADDR_CONFIG;
    wire force_wr = wr_cfg && reg_wdata[allc_pkg::FORCE_BIT];
    wire wr_office_trip = reg_wr && reg_addr == allc_pkg::ADDR_OFFICE_TRIP;
    wire wr_office_hys = reg_wr && reg_addr == allc_pkg::ADDR_OFFICE_HYS;
    wire wr_dark_trip = reg_wr && reg_addr == allc_pkg::ADDR_DARK_TRIP;
    wire wr_dark_hys = reg_wr && reg_addr == allc_pkg::ADDR_DARK_HYS;
    wire [7:0] period_steps = 8'h01 << smoothing_period;
    wire base_tick = tick_cnt == 32'(allc_pkg::BASE_CYCLES - 1);
    wire period_done = base_tick && (step_cnt + 8'h01 >= period_steps);
    wire sample = period_done || (force_req && !wr_cfg);
    wire office_status = office_bus.status;
    wire dark_status = dark_bus.status;
    wire off_stable = off_s2 == off_s3;
    wire drk_stable = drk_s2 == drk_s3;

    assign office_bus.enable = office_comparator_enable;
    assign office_bus.trip = office_threshold;
    assign office_bus.hys = office_hysteresis;
    assign office_bus.light = off_light;
    assign office_bus.sample = sample && !off_pend;
    assign dark_bus.enable = dark_comparator_enable;
    assign dark_bus.trip = dark_threshold;
    assign dark_bus.hys = dark_hysteresis;
    assign dark_bus.light = drk_light;
    assign dark_bus.sample = sample && !drk_pend;

    allc_comparator u_office (.clk(clk), .srst(srst), .ce(ce), .port(office_bus));
    allc_comparator u_dark (.clk(clk), .srst(srst), .ce(ce), .port(dark_bus));

    assign next_level = dark_status ? allc_pkg::LEVEL_DARK :
        (office_status ? allc_pkg::LEVEL_OFFICE : allc_pkg::LEVEL_DAY);
    // address pair follows the level being registered, so both move on the same edge
    wire [7:0] pair_base = allc_pkg::ADDR_LEVEL_FIRST + {5'h00, next_level - 2'h1, 1'b0};

    always_comb begin
        case (reg_addr)
            allc_pkg::ADDR_CONFIG: reg_rdata = {smoothing_period, force_req, dark_status, office_status,
                dark_comparator_enable, office_comparator_enable};
            allc_pkg::ADDR_OFFICE_TRIP: reg_rdata = {1'b0, office_threshold};
            allc_pkg::ADDR_OFFICE_HYS: reg_rdata = {1'b0, office_hysteresis};
            allc_pkg::ADDR_DARK_TRIP: reg_rdata = {1'b0, dark_threshold};
            allc_pkg::ADDR_DARK_HYS: reg_rdata = {1'b0, dark_hysteresis};
            default: reg_rdata = 8'h00;
        endcase
    end

    // one-shot sequencer: a write in the armed cycle keeps the request, so it is never lost
    assign force_req = seq_state == SEQ_ARMED;

    always_comb begin
        next_seq_state = seq_state;
        case (seq_state)
            SEQ_IDLE: begin
                if (force_wr) begin
                    next_seq_state = SEQ_ARMED;
                end
            end
            SEQ_ARMED: begin
                if (!wr_cfg) begin
                    next_seq_state = SEQ_IDLE;
                end
            end
            default: begin
                next_seq_state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            seq_state <= SEQ_IDLE;
        end else if (ce) begin
            seq_state <= next_seq_state;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            smoothing_period <= allc_pkg::CONFIG_RESET[allc_pkg::SMOOTHING_PERIOD_MSB:allc_pkg::SMOOTHING_PERIOD_LSB];
            dark_comparator_enable <= allc_pkg::CONFIG_RESET[allc_pkg::DARK_EN_BIT];
            office_comparator_enable <= allc_pkg::CONFIG_RESET[allc_pkg::OFFICE_EN_BIT];
        end else if (ce && wr_cfg) begin
            smoothing_period <= reg_wdata[allc_pkg::SMOOTHING_PERIOD_MSB:allc_pkg::SMOOTHING_PERIOD_LSB];
            dark_comparator_enable <= reg_wdata[allc_pkg::DARK_EN_BIT];
            office_comparator_enable <= reg_wdata[allc_pkg::OFFICE_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            office_threshold <= allc_pkg::FIELD_RESET;
        end else if (ce && wr_office_trip) begin
            office_threshold <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            office_hysteresis <= allc_pkg::FIELD_RESET;
        end else if (ce && wr_office_hys) begin
            office_hysteresis <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dark_threshold <= allc_pkg::FIELD_RESET;
        end else if (ce && wr_dark_trip) begin
            dark_threshold <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dark_hysteresis <= allc_pkg::FIELD_RESET;
        end else if (ce && wr_dark_hys) begin
            dark_hysteresis <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tick_cnt <= 32'h0;
            step_cnt <= 8'h00;
        end else if (ce) begin
            tick_cnt <= base_tick ? 32'h0 : tick_cnt + 32'h1;
            if (period_done) begin
                step_cnt <= 8'h00;
            end else if (base_tick) begin
                step_cnt <= step_cnt + 8'h01;
            end
        end
    end

    // a code change since the last sample makes the next sample be skipped
    always_ff @(posedge clk) begin
        if (srst) begin
            off_pend <= 1'b0;
            drk_pend <= 1'b0;
        end else if (ce) begin
            if (sample) begin
                off_pend <= 1'b0;
                drk_pend <= 1'b0;
            end else begin
                off_pend <= off_pend | !off_stable;
                drk_pend <= drk_pend | !drk_stable;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            {off_s1, off_s2, off_s3, off_light} <= 28'h0;
        end else if (ce) begin
            off_s1 <= office_light_code;
            off_s2 <= off_s1;
            off_s3 <= off_s2;
            if (off_stable) begin
                off_light <= off_s3;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            {drk_s1, drk_s2, drk_s3, drk_light} <= 28'h0;
        end else if (ce) begin
            drk_s1 <= dark_light_code;
            drk_s2 <= drk_s1;
            drk_s3 <= drk_s2;
            if (drk_stable) begin
                drk_light <= drk_s3;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            backlight_light_level <= allc_pkg::LEVEL_DAY;
            level_max_addr <= allc_pkg::ADDR_LEVEL_FIRST;
            level_dim_addr <= allc_pkg::ADDR_LEVEL_FIRST + 8'h01;
        end else if (ce) begin
            backlight_light_level <= next_level;
            level_max_addr <= pair_base;
            level_dim_addr <= pair_base + 8'h01;
        end
    end
endmodule : allc_light_comparator

//--- allc_pkg.sv
package allc_pkg;
    localparam logic [7:0] ADDR_CONFIG = 8'h0c;
    localparam logic [7:0] ADDR_OFFICE_TRIP = 8'h0d;
    localparam logic [7:0] ADDR_OFFICE_HYS = 8'h0e;
    localparam logic [7:0] ADDR_DARK_TRIP = 8'h0f;
    localparam logic [7:0] ADDR_DARK_HYS = 8'h10;
    localparam logic [7:0] ADDR_LEVEL_FIRST = 8'h05;
    localparam logic [7:0] ADDR_LEVEL_LAST = 8'h0a;
    localparam int SMOOTHING_PERIOD_MSB = 7;
    localparam int SMOOTHING_PERIOD_LSB = 5;
    localparam int FORCE_BIT = 4;
    localparam int DARK_ST_BIT = 3;
    localparam int OFFICE_ST_BIT = 2;
    localparam int DARK_EN_BIT = 1;
    localparam int OFFICE_EN_BIT = 0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [6:0] FIELD_RESET = 7'h00;
    localparam int CLK_HZ = 20000000;
    localparam int BASE_PERIOD_MS = 80;
    localparam int BASE_CYCLES = CLK_HZ / 1000 * BASE_PERIOD_MS;
    localparam logic [1:0] LEVEL_DAY = 2'h1;
    localparam logic [1:0] LEVEL_OFFICE = 2'h2;
    localparam logic [1:0] LEVEL_DARK = 2'h3;
endpackage : allc_pkg

//--- allc_cmp_if.sv
`timescale 1ns/1ps
interface allc_cmp_if;
    logic enable;
    logic [6:0] trip;
    logic [6:0] hys;
    logic [6:0] light;
    logic sample;
    logic status;
    modport ctrl (output enable, output trip, output hys, output light, output sample, input status);
    modport cmp (input enable, input trip, input hys, input light, input sample, output status);
endinterface : allc_cmp_if

//--- allc_comparator.sv
`timescale 1ns/1ps
module allc_comparator (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    allc_cmp_if.cmp port
);
    logic status;
    wire [7:0] release_level = {1'b0, port.trip} + {1'b0, port.hys};
    wire below = port.light < port.trip;
    wire above = {1'b0, port.light} > release_level;
    assign port.status = status;
    always_ff @(posedge clk) begin
        if (srst) begin
            status <= 1'b0;
        end else if (ce) begin
            if (!port.enable) begin
                status <= 1'b0;
            end else if (port.sample && below) begin
                status <= 1'b1;
            end else if (port.sample && above) begin
                status <= 1'b0;
            end
        end
    end
endmodule : allc_comparator

//--- allc_monitor.sv
`timescale 1ns/1ps
module allc_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [6:0] office_light_code,
    input wire logic [6:0] dark_light_code,
    input wire logic [1:0] backlight_light_level,
    input wire logic [7:0] level_max_addr,
    input wire logic [7:0] level_dim_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire logic cfg_rd = ce && reg_addr == allc_pkg::ADDR_CONFIG;
    wire logic [6:0] wdata_field = reg_wdata[6:0];
    wire logic field_wr = ce && reg_wr && reg_addr inside {[allc_pkg::ADDR_OFFICE_TRIP:allc_pkg::ADDR_DARK_HYS]};
    sequence s_force_wr; cfg_rd && reg_wr && reg_wdata[4]; endsequence
    sequence s_cfg_idle; cfg_rd && !reg_wr; endsequence
    chk_force_seen: assert property (s_force_wr |=> !cfg_rd || reg_rdata[4]) else $error("force bit lost");
    chk_force_clear: assert property (s_force_wr ##1 s_cfg_idle |=> !cfg_rd || !reg_rdata[4])
        else $error("force bit stuck");
    chk_level_dark: assert property (cfg_rd && reg_rdata[3] |=> backlight_light_level == allc_pkg::LEVEL_DARK)
        else $error("level not dark");
    chk_level_office: assert property (cfg_rd && reg_rdata[3:2] == 2'h1 |=> backlight_light_level == 2'h2)
        else $error("level not office");
    chk_level_day: assert property (cfg_rd && reg_rdata[3:2] == 2'h0 |=> backlight_light_level == 2'h1)
        else $error("level not daylight");
    chk_dark_gated: assert property (cfg_rd && !reg_rdata[1] && $past(cfg_rd && !reg_rdata[1]) |-> !reg_rdata[3])
        else $error("dark status while disabled");
    chk_office_gated: assert property (cfg_rd && !reg_rdata[0] && $past(cfg_rd && !reg_rdata[0]) |-> !reg_rdata[2])
        else $error("office status while disabled");
    chk_max_addr: assert property (level_max_addr == (8'(backlight_light_level) << 1) + 8'h03)
        else $error("max address wrong");
    chk_dim_addr: assert property (level_dim_addr == level_max_addr + 8'h01) else $error("dim address wrong");
    chk_field_write: assert property (field_wr |=>
        reg_addr != $past(reg_addr) || reg_rdata == {1'b0, $past(wdata_field)}) else $error("field write lost");
endmodule : allc_monitor
bind allc_light_comparator allc_monitor i_allc_monitor (.*);

//--- allc_sensor_model.sv
`timescale 1ns/1ps
module allc_sensor_model (
    input wire logic [6:0] office_level,
    input wire logic [6:0] dark_level,
    output logic [6:0] office_light_code,
    output logic [6:0] dark_light_code
);
    // codes settle off the clock grid after the light changes
    assign #7 office_light_code = office_level;
    assign #7 dark_light_code = dark_level;
endmodule : allc_sensor_model

//--- tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, level_max_addr, level_dim_addr;
    logic [6:0] office_level = 7'h7f;
    logic [6:0] dark_level = 7'h7f;
    logic [6:0] office_light_code, dark_light_code;
    logic [1:0] backlight_light_level;
    int fails = 0;
    int n_tests = 0;
    always #25 clk = ~clk;
    allc_sensor_model i_allc_sensor_model (
        .office_level(office_level),
        .dark_level(dark_level),
        .office_light_code(office_light_code),
        .dark_light_code(dark_light_code)
    );
    allc_light_comparator i_allc_light_comparator (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .office_light_code(office_light_code),
        .dark_light_code(dark_light_code),
        .backlight_light_level(backlight_light_level),
        .level_max_addr(level_max_addr),
        .level_dim_addr(level_dim_addr)
    );
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #2 reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #2 reg_addr = a;
        #3 chk("register", exp, reg_rdata);
    endtask : rd
    // force n conversions, then check config and level outputs
    task automatic conv(input int n, input logic [7:0] c, input logic [7:0] exp, input logic [1:0] l);
        repeat (6) @(posedge clk);
        repeat (n) begin
            wr(allc_pkg::ADDR_CONFIG, c | 8'h10);
            for (int i = 0; i < 20 && reg_rdata[4] !== 1'b0; i++) #50;
            if (reg_rdata[4] !== 1'b0) begin
                chk("force bit", 8'h00, {7'h00, reg_rdata[4]});
                close_out();
            end
        end
        repeat (3) @(posedge clk);
        rd(allc_pkg::ADDR_CONFIG, exp);
        chk("level", {6'h00, l}, {6'h00, backlight_light_level});
        chk("max addr", 8'h03 + {5'h00, l, 1'b0}, level_max_addr);
        chk("dim addr", 8'h04 + {5'h00, l, 1'b0}, level_dim_addr);
    endtask : conv
    initial begin
        repeat (4) @(posedge clk);
        #2 srst = 1'b0;
        for (int a = 12; a < 18; a++) rd(8'(a), 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(allc_pkg::ADDR_CONFIG, {3'(i), 5'h03});
            rd(allc_pkg::ADDR_CONFIG, {3'(i), 5'h03});
        end
        wr(allc_pkg::ADDR_CONFIG, 8'h0f);
        rd(allc_pkg::ADDR_CONFIG, 8'h03);
        wr(allc_pkg::ADDR_OFFICE_TRIP, 8'hc0);
        rd(allc_pkg::ADDR_OFFICE_TRIP, 8'h40);
        wr(allc_pkg::ADDR_OFFICE_HYS, 8'h10);
        wr(allc_pkg::ADDR_DARK_TRIP, 8'h20);
        wr(allc_pkg::ADDR_DARK_HYS, 8'h88);
        rd(allc_pkg::ADDR_DARK_HYS, 8'h08);
        wr(8'h11, 8'hff);
        rd(8'h11, 8'h00);
        @(posedge clk);
        #2 ce = 1'b0;
        wr(allc_pkg::ADDR_OFFICE_HYS, 8'h33);
        ce = 1'b1;
        rd(allc_pkg::ADDR_OFFICE_HYS, 8'h10);
        conv(2, 8'h03, 8'h03, 2'h1);
        office_level = 7'h3f;
        conv(1, 8'h03, 8'h03, 2'h1);
        conv(1, 8'h03, 8'h07, 2'h2);
        office_level = 7'h50;
        conv(2, 8'h03, 8'h07, 2'h2);
        office_level = 7'h51;
        conv(2, 8'h03, 8'h03, 2'h1);
        office_level = 7'h3f;
        dark_level = 7'h1f;
        conv(2, 8'h03, 8'h0f, 2'h3);
        dark_level = 7'h28;
        conv(2, 8'h03, 8'h0f, 2'h3);
        dark_level = 7'h29;
        conv(2, 8'h03, 8'h07, 2'h2);
        dark_level = 7'h1f;
        conv(2, 8'h01, 8'h05, 2'h2);
        conv(2, 8'h00, 8'h00, 2'h1);
        close_out();
    end
endmodule : tb
